/* File: gp_ext_model.sv */
/*
  gp_ext_model: outside circuitry on the port 7 and port 8 pins.
  assumes the bench picks the level that the far side drives on a released pin.
*/
`timescale 1ns/1ns
`default_nettype none

module gp_ext_model (
  // design drive
  input  wire logic [7:0] p7_out,
  input  wire logic [7:0] p7_oe,
  input  wire logic [7:0] p8_out,
  input  wire logic [7:0] p8_oe,
  // far side drive
  input  wire logic [7:0] ext7,
  input  wire logic [7:0] ext8,
  // wire levels
  output logic      [7:0] p7_in,
  output logic      [7:0] p8_in
);
  // no pull-ups, so a released pin shows only the far side
  assign p7_in = (p7_oe & p7_out) | (~p7_oe & ext7);
  assign p8_in = (p8_oe & p8_out) | (~p8_oe & ext8);
endmodule

`default_nettype wire

/* File: gp_pin_mux.sv */
/*
  gp_pin_mux: one 8-bit port's output mux and read-back merge.
  assumes direction, data and timer ownership come from registers upstream.
*/
`timescale 1ns/1ns
`default_nettype none

module gp_pin_mux #(
  parameter int unsigned W = 8
) (
  // port settings
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] data,
  input  wire logic [W-1:0] pin_in,
  // timer ownership
  input  wire logic [W-1:0] tmr_own,
  input  wire logic [W-1:0] tmr_out,
  // results
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] rd_val
);

  // timer owns pin: drive timer level, latch stays untouched
  assign pin_out = (tmr_own & tmr_out) | (~tmr_own & data);
  assign pin_oe  = tmr_own | dir;
  // outputs read the latch, inputs read the pin
  assign rd_val  = (dir & data) | (~dir & pin_in);

endmodule

`default_nettype wire

/* File: gp_pkg.sv */
/*
  gp_pkg: register map, field layout, reset values and pin-mux codes
  for the port 5/7/8 pin-sharing block.
  assumes a plain register port with 8-bit data and 3-bit word index.
*/
package gp_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register indices
  localparam logic [2:0] OFF_P5_FUNC = 3'h0;
  localparam logic [2:0] OFF_P5_DIR  = 3'h1;
  localparam logic [2:0] OFF_P7_DIR  = 3'h2;
  localparam logic [2:0] OFF_P7_DATA = 3'h3;
  localparam logic [2:0] OFF_P8_DIR  = 3'h4;
  localparam logic [2:0] OFF_P8_DATA = 3'h5;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;

  // port 7 implemented bits 6..4, reserved read as one
  localparam logic [7:0] P7_IMPL_MASK = 8'h70;
  localparam logic [7:0] P7_RSVD_ONES = 8'h8F;
  localparam int unsigned P7_TMO_BIT  = 6;
  localparam int unsigned P7_CLK_BIT  = 5;
  localparam int unsigned P7_RST_BIT  = 4;

  // port 5 trigger bit
  localparam int unsigned P5_TRIG_BIT = 5;

  // port 8 timer-w pins
  localparam int unsigned P8_CLK_BIT   = 0;
  localparam int unsigned P8_TW_LO_BIT = 1;
  localparam int unsigned P8_TW_HI_BIT = 4;

  // timer-v select value meaning general i/o
  localparam logic [3:0] TV_SEL_GPIO = 4'h0;

  // timer-w io select codes that drive the pin
  localparam logic [2:0] TW_SEL_OUT1 = 3'h1;
  localparam logic [1:0] TW_SEL_OUT2 = 2'h1;

  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gp_req_t;

  // per-port pin bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gp_pins_t;

endpackage

/* File: gp_ports.sv */
/*
  gp_ports: port 5 function select, ports 7 and 8 direction/data with
  timer-v and timer-w pin sharing.
  assumes pins are synchronous to clk; external logic builds the wire level.
*/
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// (RULE_01) port-5 select 0 gives gpio by direction; 1 gives wake-up, bit5 trigger
// (RULE_02) port-5 wake-up selects reset to zero, so pins start as gpio
// (RULE_03) nonzero timer-v output select overrides port-7 bit 6 direction
// (RULE_04) port-7 bits 5 and 4 always feed timer-v clock and reset
// (RULE_05) port-7 direction bits 6..4 write-only, reset zero, others reserved
// (RULE_06) port-7 data bits 6..4 reset zero, driven on gpio outputs
// (RULE_07) port-7 data read: outputs give latch, inputs give pin
// (RULE_08) port-7 data reserved bits 7 and 3..0 read one
// (RULE_09) timer-w settings override port-8 bits 4..1
// (RULE_10) port-8 bit 0 always feeds timer-w clock input
// (RULE_11) port-8 direction eight write-only bits, reset zero
// (RULE_12) port-8 data eight bits, reset zero, driven on gpio outputs
// (RULE_13) port-8 data read: outputs give latch, inputs give pin
// (RULE_14) timer-w select 001 or 01x makes pin a timer output
// (RULE_15) writes land next edge; write-only registers read as zero
// (RULE_16) timer-owned pin driven by timer, latch stays writable
module gp_ports (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // register port
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [2:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // port 5 pins
  input  wire logic [7:0]              p5_in,
  output logic      [7:0]              p5_dir_out,
  output logic      [7:0]              wakeup_en,
  output logic                         converter_trigger_in,
  output logic      [7:0]              wakeup_in,
  // port 7 pins
  input  wire logic [7:0]              p7_in,
  output logic      [7:0]              p7_out,
  output logic      [7:0]              p7_oe,
  // timer v
  input  wire logic [3:0]              timer_v_output_select,
  input  wire logic                    timer_v_compare_out,
  output logic                         timer_v_clock_in,
  output logic                         timer_v_reset_in,
  // port 8 pins
  input  wire logic [7:0]              p8_in,
  output logic      [7:0]              p8_out,
  output logic      [7:0]              p8_oe,
  // timer w
  input  wire logic [5:0]              timer_w_io_ctrl_ab,
  input  wire logic [5:0]              timer_w_io_ctrl_cd,
  input  wire logic [3:0]              timer_w_out,
  output logic      [3:0]              timer_w_in,
  output logic                         timer_w_clock_in
);

  gp_pkg::gp_req_t  req;
  logic [7:0]       p5_func_r;
  logic [7:0]       p5_dir_r;
  logic [7:0]       p7_dir_r;
  logic [7:0]       p7_data_r;
  logic [7:0]       p8_dir_r;
  logic [7:0]       p8_data_r;
  logic [7:0]       rdata_nxt;
  logic [7:0]       p7_own;
  logic [7:0]       p7_tout;
  logic [7:0]       p8_own;
  logic [7:0]       p8_tout;
  logic [3:0]       tw_own;
  gp_pkg::gp_pins_t p7_mux;
  gp_pkg::gp_pins_t p8_mux;
  logic [7:0]       p7_rd;
  logic [7:0]       p8_rd;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // timer-w select: 001 or 01x drives the pin
  function automatic logic tw_drives(input logic [2:0] sel);
    tw_drives = (sel == gp_pkg::TW_SEL_OUT1) || (sel[2:1] == gp_pkg::TW_SEL_OUT2);
  endfunction

  // register writes
  // (RULE_02) selects clear
  always_ff @(posedge clk) begin
    if (rst) begin
      p5_func_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P5_FUNC) begin
      p5_func_r <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      p5_dir_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P5_DIR) begin
      p5_dir_r <= req.wdata;
    end
  end

  // (RULE_05) implemented bits only
  always_ff @(posedge clk) begin
    if (rst) begin
      p7_dir_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P7_DIR) begin
      p7_dir_r <= req.wdata & gp_pkg::P7_IMPL_MASK;
    end
  end

  // (RULE_06) latch bits 6..4
  always_ff @(posedge clk) begin
    if (rst) begin
      p7_data_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P7_DATA) begin
      p7_data_r <= req.wdata & gp_pkg::P7_IMPL_MASK;
    end
  end

  // (RULE_11) eight write-only bits
  always_ff @(posedge clk) begin
    if (rst) begin
      p8_dir_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P8_DIR) begin
      p8_dir_r <= req.wdata;
    end
  end

  // (RULE_12) eight data bits
  // (RULE_16) latch writable while timer owns
  always_ff @(posedge clk) begin
    if (rst) begin
      p8_data_r <= gp_pkg::RST_ZERO;
    end else if (req.wr && req.addr == gp_pkg::OFF_P8_DATA) begin
      p8_data_r <= req.wdata;
    end
  end

  // timer ownership
  // (RULE_03) timer-v select priority
  always_comb begin
    p7_own  = 8'h00;
    p7_tout = 8'h00;
    p7_own[gp_pkg::P7_TMO_BIT]  = (timer_v_output_select != gp_pkg::TV_SEL_GPIO);
    p7_tout[gp_pkg::P7_TMO_BIT] = timer_v_compare_out;
  end

  // (RULE_09) timer-w precedence
  // (RULE_14) select code decode
  assign tw_own = {tw_drives(timer_w_io_ctrl_cd[5:3]), tw_drives(timer_w_io_ctrl_cd[2:0]),
                   tw_drives(timer_w_io_ctrl_ab[5:3]), tw_drives(timer_w_io_ctrl_ab[2:0])};
  assign p8_own  = {3'h0, tw_own, 1'h0};
  assign p8_tout = {3'h0, timer_w_out, 1'h0};

  // (RULE_07) port-7 mux and read merge
  gp_pin_mux #(.W(8)) u_p7 (
    .dir     (p7_dir_r),
    .data    (p7_data_r),
    .pin_in  (p7_in),
    .tmr_own (p7_own),
    .tmr_out (p7_tout),
    .pin_out (p7_mux.out),
    .pin_oe  (p7_mux.oe),
    .rd_val  (p7_rd)
  );

  // (RULE_13) port-8 mux and read merge
  gp_pin_mux #(.W(8)) u_p8 (
    .dir     (p8_dir_r),
    .data    (p8_data_r),
    .pin_in  (p8_in),
    .tmr_own (p8_own),
    .tmr_out (p8_tout),
    .pin_out (p8_mux.out),
    .pin_oe  (p8_mux.oe),
    .rd_val  (p8_rd)
  );

  // read data, one cycle after the strobe
  // (RULE_15) write-only read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (req.addr)
      gp_pkg::OFF_P5_FUNC: rdata_nxt = p5_func_r;
      // (RULE_08) reserved bits one
      gp_pkg::OFF_P7_DATA: rdata_nxt = (p7_rd & gp_pkg::P7_IMPL_MASK) | gp_pkg::P7_RSVD_ONES;
      gp_pkg::OFF_P8_DATA: rdata_nxt = p8_rd;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // registered pins; one cycle after settings change
  always_ff @(posedge clk) begin
    if (rst) begin
      p7_out <= 8'h00;
      p7_oe  <= 8'h00;
      p8_out <= 8'h00;
      p8_oe  <= 8'h00;
    end else begin
      p7_out <= p7_mux.out;
      p7_oe  <= p7_mux.oe;
      p8_out <= p8_mux.out;
      p8_oe  <= p8_mux.oe;
    end
  end

  // (RULE_01) port-5 function split
  always_ff @(posedge clk) begin
    if (rst) begin
      p5_dir_out           <= 8'h00;
      wakeup_en            <= 8'h00;
      wakeup_in            <= 8'h00;
      converter_trigger_in <= 1'b0;
    end else begin
      p5_dir_out           <= p5_dir_r & ~p5_func_r;
      wakeup_en            <= p5_func_r;
      wakeup_in            <= p5_in & p5_func_r;
      converter_trigger_in <= p5_in[gp_pkg::P5_TRIG_BIT] & p5_func_r[gp_pkg::P5_TRIG_BIT];
    end
  end

  // (RULE_04) timer-v inputs always routed
  // (RULE_10) timer-w clock always routed
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_v_clock_in <= 1'b0;
      timer_v_reset_in <= 1'b0;
      timer_w_clock_in <= 1'b0;
      timer_w_in       <= 4'h0;
    end else begin
      timer_v_clock_in <= p7_in[gp_pkg::P7_CLK_BIT];
      timer_v_reset_in <= p7_in[gp_pkg::P7_RST_BIT];
      timer_w_clock_in <= p8_in[gp_pkg::P8_CLK_BIT];
      timer_w_in       <= p8_in[gp_pkg::P8_TW_HI_BIT:gp_pkg::P8_TW_LO_BIT];
    end
  end

  // assertions
  property p_p7_rsvd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == gp_pkg::OFF_P7_DATA |=> (reg_rdata & 8'h8F) == 8'h8F;
  endproperty
  a_p7_rsvd: assert property (p_p7_rsvd) else $error("port7 reserved bits not one"); // RULE_08

  property p_tv_own;
    @(posedge clk) disable iff (rst)
      timer_v_output_select != 4'h0 |=> p7_oe[6] && p7_out[6] == $past(timer_v_compare_out);
  endproperty
  a_tv_own: assert property (p_tv_own) else $error("timer v pin not driven"); // RULE_03

  property p_tv_gpio;
    @(posedge clk) disable iff (rst)
      timer_v_output_select == 4'h0 |=> p7_oe[6] == $past(p7_dir_r[6]);
  endproperty
  a_tv_gpio: assert property (p_tv_gpio) else $error("port7 bit6 oe wrong"); // RULE_03

  property p_p7_wr;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == gp_pkg::OFF_P7_DIR |=> p7_dir_r == (8'h70 & $past(reg_wdata));
  endproperty
  a_p7_wr: assert property (p_p7_wr) else $error("port7 direction write lost"); // RULE_05

  property p_p8_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == gp_pkg::OFF_P8_DATA
      |=> reg_rdata == (($past(p8_dir_r) & $past(p8_data_r)) | (~$past(p8_dir_r) & $past(p8_in)));
  endproperty
  a_p8_rd: assert property (p_p8_rd) else $error("port8 read merge wrong"); // RULE_13

  property p_p7_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == gp_pkg::OFF_P7_DATA && p7_dir_r[5] |=> reg_rdata[5] == $past(p7_data_r[5]);
  endproperty
  a_p7_rd: assert property (p_p7_rd) else $error("port7 latch read wrong"); // RULE_07

  property p_tw_clk;
    @(posedge clk) disable iff (rst) 1'b1 |=> timer_w_clock_in == $past(p8_in[0]);
  endproperty
  a_tw_clk: assert property (p_tw_clk) else $error("timer w clock not routed"); // RULE_10

  property p_tv_in;
    @(posedge clk) disable iff (rst)
      1'b1 |=> timer_v_clock_in == $past(p7_in[5]) && timer_v_reset_in == $past(p7_in[4]);
  endproperty
  a_tv_in: assert property (p_tv_in) else $error("timer v inputs not routed"); // RULE_04

  property p_tw_out;
    @(posedge clk) disable iff (rst)
      timer_w_io_ctrl_ab[2:0] == 3'h1 |=> p8_oe[1] && p8_out[1] == $past(timer_w_out[0]);
  endproperty
  a_tw_out: assert property (p_tw_out) else $error("timer w pin not driven"); // RULE_14

  property p_wk;
    @(posedge clk) disable iff (rst) p5_func_r[3] |=> !p5_dir_out[3];
  endproperty
  a_wk: assert property (p_wk) else $error("wake-up pin still output"); // RULE_01

  property p_p8_wr;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == gp_pkg::OFF_P8_DATA |=> p8_data_r == $past(reg_wdata);
  endproperty
  a_p8_wr: assert property (p_p8_wr) else $error("port8 data write lost"); // RULE_12

  property p_rd_idle;
    @(posedge clk) disable iff (rst) !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared"); // RULE_15

  property p_wo_rd;
    @(posedge clk) disable iff (rst)
      reg_rd && (reg_addr == gp_pkg::OFF_P7_DIR || reg_addr == gp_pkg::OFF_P8_DIR)
      |=> reg_rdata == 8'h00;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("write-only read not zero"); // RULE_15

  property p_tw_gpio;
    @(posedge clk) disable iff (rst)
      timer_w_io_ctrl_cd[5]
      |=> p8_oe[4] == $past(p8_dir_r[4]) && p8_out[4] == $past(p8_data_r[4]);
  endproperty
  a_tw_gpio: assert property (p_tw_gpio) else $error("port8 bit4 not gpio"); // RULE_14

  c_p7_read:  cover property (@(posedge clk) reg_rd && reg_addr == gp_pkg::OFF_P7_DATA);
  c_p8_read:  cover property (@(posedge clk) reg_rd && reg_addr == gp_pkg::OFF_P8_DATA);
  c_tv_owned: cover property (@(posedge clk) p7_oe[6] && !p7_dir_r[6]);
  c_tw_owned: cover property (@(posedge clk) |p8_own);
  c_p5_trig:  cover property (@(posedge clk) converter_trigger_in);

endmodule

`default_nettype wire

/* File: gp_ports_tb.sv */
/*
  gp_ports_tb: random register writes and pin traffic against a bench model.
  assumes the register port and pin timing of gp_ports, one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module gp_ports_tb;
  logic       clk, rst, reg_wr, reg_rd, tvc, tv_clk, tv_rst, tw_clk, trig;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, p5, p5_dir_out, wakeup_en, wakeup_in;
  logic [7:0] p7_in, p7_out, p7_oe, p8_in, p8_out, p8_oe, e7, e8, rd;
  logic [7:0] m5s, m5d, m7d, m7q, m8d, m8q;
  logic [3:0] tvs, two, tw_in;
  logic [5:0] tab, tcd;
  logic [31:0] r;
  integer     seed, n_fail, comparisons, cycles, n;

  gp_ports gp_ports_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .p5_in(p5),
    .p5_dir_out(p5_dir_out), .wakeup_en(wakeup_en), .converter_trigger_in(trig),
    .wakeup_in(wakeup_in), .p7_in(p7_in), .p7_out(p7_out), .p7_oe(p7_oe),
    .timer_v_output_select(tvs), .timer_v_compare_out(tvc),
    .timer_v_clock_in(tv_clk), .timer_v_reset_in(tv_rst), .p8_in(p8_in),
    .p8_out(p8_out), .p8_oe(p8_oe), .timer_w_io_ctrl_ab(tab),
    .timer_w_io_ctrl_cd(tcd), .timer_w_out(two), .timer_w_in(tw_in),
    .timer_w_clock_in(tw_clk));

  gp_ext_model gp_ext_model_i (.p7_out(p7_out), .p7_oe(p7_oe), .p8_out(p8_out),
    .p8_oe(p8_oe), .ext7(e7), .ext8(e8), .p7_in(p7_in), .p8_in(p8_in));

  always #20 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // unmapped indices 6 and 7 leave the model alone
    case (a)
      3'h0: m5s = d;
      3'h1: m5d = d;
      3'h2: m7d = d & 8'h70;
      3'h3: m7q = d & 8'h70;
      3'h4: m8d = d;
      3'h5: m8q = d;
      default: ;
    endcase
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check_all();
    logic [7:0] o7, q7, o8, q8, w7, w8, v;
    logic [2:0] s;
    integer     i;
    o7 = m7d;
    q7 = m7q;
    if (tvs !== 4'h0) begin
      o7[6] = 1'b1;
      q7[6] = tvc;
    end
    o8 = m8d;
    q8 = m8q;
    for (i = 1; i < 5; i++) begin
      s = (i < 3) ? tab[3*(i-1) +: 3] : tcd[3*(i-3) +: 3];
      if (s == 3'h1 || s[2:1] == 2'h1) begin
        o8[i] = 1'b1;
        q8[i] = two[i-1];
      end
    end
    w7 = (o7 & q7) | (~o7 & e7);
    w8 = (o8 & q8) | (~o8 & e8);
    chk(p7_oe, o7);
    chk(p7_out & o7, q7 & o7);
    chk(p8_oe, o8);
    chk(p8_out & o8, q8 & o8);
    chk({6'h00, tv_clk, tv_rst}, {6'h00, w7[5:4]});
    chk({3'h0, tw_in, tw_clk}, {3'h0, w8[4:0]});
    chk(p5_dir_out, m5d & ~m5s);
    chk(wakeup_en, m5s);
    chk(wakeup_in, p5 & m5s);
    chk({7'h00, trig}, {7'h00, p5[5] & m5s[5]});
    rd_reg(3'h3, v);
    chk(v, (((m7d & m7q) | (~m7d & w7)) & 8'h70) | 8'h8F);
    rd_reg(3'h5, v);
    chk(v, (m8d & m8q) | (~m8d & w8));
    rd_reg(3'h0, v);
    chk(v, m5s);
  endtask

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  initial begin
    {clk, reg_wr, reg_rd, tvc, reg_addr, reg_wdata, p5, e7, e8} = '0;
    {m5s, m5d, m7d, m7q, m8d, m8q, tvs, two, tab, tcd} = '0;
    {n_fail, comparisons, cycles} = '0;
    seed = 41;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_all();
    rd_reg(3'h2, rd);
    chk(rd, 8'h00);
    for (n = 0; n < 300; n++) begin
      repeat (3) begin
        r = $random(seed);
        wr_reg(r[2:0], r[15:8]);
      end
      @(posedge clk);
      r = $random(seed);
      e7  <= r[7:0];
      p5  <= r[15:8];
      e8  <= r[23:16];
      tvs <= r[27:24] & {4{r[28]}};
      tvc <= r[29];
      r = $random(seed);
      tab <= r[5:0];
      tcd <= r[11:6];
      two <= r[15:12];
      // pins and timer inputs are registered, let them settle
      repeat (3) @(posedge clk);
      #1;
      check_all();
    end
    // write-only and unmapped indices read zero with registers loaded
    for (n = 1; n < 8; n++) begin
      if (n != 3 && n != 5) begin
        rd_reg(n[2:0], rd);
        chk(rd, 8'h00);
      end
    end
    @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00);
    // second reset in mid-run, timer inputs left as they are
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(p7_oe | p8_oe | p5_dir_out, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    {m5s, m5d, m7d, m7q, m8d, m8q} = '0;
    repeat (3) @(posedge clk);
    #1;
    check_all();
    final_report();
  end
endmodule

`default_nettype wire
